// ---- hdl/lane_engine_pkg.sv ----
// constants, types and register map of the lane transition engine
// assumes one lane clock; local memory answers a read with a one-cycle ack
package lane_engine_pkg;

    localparam int QD  = 8;                       // entries per activation queue
    localparam int CW  = 4;                       // queue count width
    localparam int PW  = 16;                      // pointer and memory address width

    // transition word and property type codes (property null = basic)
    typedef enum logic [3:0] {
        TT_BASIC    = 4'h0, TT_EPS      = 4'h1, TT_REFILL   = 4'h2, TT_MAJ      = 4'h3,
        TT_DEF      = 4'h4, TT_FLAG     = 4'h5, TT_COMMON   = 4'h6, TT_PERSIST  = 4'h7,
        TT_FLAGMAJ  = 4'h8, TT_FLAGDEF  = 4'h9, TT_BASICWA  = 4'hA, TT_REFILLWA = 4'hB,
        TT_FLAGWA   = 4'hC, TT_COMMONWA = 4'hD, TT_RSV14    = 4'hE, TT_RSV15    = 4'hF
    } ttype_t;

    typedef struct packed {
        logic [7:0]  sig;
        logic [11:0] tgt;
        ttype_t      typ;
        logic [7:0]  att;
    } tword_t;

    typedef struct packed {
        logic [11:0] tgt;
        ttype_t      ptype;
        logic [7:0]  pval;
    } act_t;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_POP  = 5'h02,
        S_WAIT = 5'h04,
        S_EXEC = 5'h08,
        S_END  = 5'h10
    } state_t;

    // register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_REG0 = 12'h004;
    localparam logic [11:0] OFS_DSB  = 12'h008;
    localparam logic [11:0] OFS_SBP  = 12'h00C;
    localparam logic [11:0] OFS_PUSH = 12'h010;

    // control register bit positions
    localparam int CB_RUN   = 0;
    localparam int CB_ISSUE = 1;                  // three bits from here
    localparam int CB_DEFID = 4;
    localparam int CB_HOLD  = 8;
    localparam int CB_DEAD  = 9;
    localparam int CB_BUSY  = 10;

    localparam logic [2:0]    ISSUE_RST = 3'h1;
    localparam logic [1:0]    MODE_REL  = 2'h3;
    localparam logic [2:0]    BASE_ONE  = 3'h7;

    // relative action address of the mode-11 scheme
    function automatic logic [PW-1:0] rel_addr(input logic [2:0] bidx,
                                               input logic [2:0] sidx,
                                               input logic [7:0] sig);
        logic [PW-1:0] b;
        b = 16'h0001;
        case (bidx)
            3'h0: b = 16'h0001;
            3'h1: b = 16'h0002;
            3'h2: b = 16'h0004;
            3'h3: b = 16'h0008;
            3'h4: b = 16'h0010;
            3'h5: b = 16'h0040;
            3'h6: b = 16'h0100;
            default: b = 16'h0001;
        endcase
        if (bidx == BASE_ONE)
            rel_addr = 16'h0001;
        else
            rel_addr = b + ({8'h00, sig} << sidx);
    endfunction : rel_addr

endpackage : lane_engine_pkg

// ---- hdl/lane_transition_engine.sv ----
// transition execution engine of one accelerator lane, with an APB register slave
// assumes local memory acks each read pulse once, and a stream buffer word at the pointer
// Overview of operation
// - pop activations, fetch and execute; when empty swap queues and clear next
// - at stage end pointer advances by issue width minus last refill
// - basic, refill, persistent property: pointer is target plus input word
// - common property: pointer is target alone
// - flag properties: pointer is target plus lane register zero
// - signature passes when the label equals the word signature, or unchecked on the word after an epsilon or majority fetch
// - basic success pushes target with null property
// - with-action basic or refill also fetches first action word, basic by mode, refill always by the mode-11 relative address
// - majority and default carry push target with type and attach value
// - persistent, flag, common carry push target with type, null value
// - flag-majority and flag-default push target with type and attach value
// - refill word lowers the pointer by its refill value
// - epsilon fetches a further word at its attach field
// - failure with majority property fetches the majority transition
// - failure with default property fetches the default transition
// - failure otherwise marks the activation dead and sets the dead flag
// - default and majority words store attach as value, type copied
// - common word building a property sets the hold flag
// - label transition needs success, then pushes target with property
// - default by address fetches twice; by identifier fetches value plus input
// - default chains one deep, no actions follow a default (here a with-action word reached by a default still requests its action)
// - flagged transition uses lane register zero as the label
// - word holds signature 8, target 12, type 4, attach 8
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module lane_transition_engine
    import lane_engine_pkg::*;
(
    input  wire logic                         clock,
    input  wire logic                         arst_n,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [11:0]                  paddr,
    input  wire logic [31:0]                  pwdata,
    output logic                              pready,
    output logic [31:0]                       prdata,
    output logic                              pslverr,
    output logic                              memRd,
    output logic [lane_engine_pkg::PW-1:0]    memAddr,
    input  wire logic                         memAck,
    input  wire logic [31:0]                  memRdata,
    output logic [lane_engine_pkg::PW-1:0]    streamPtr,
    input  wire logic [7:0]                   streamWord,
    output logic                              actReq,
    output logic [lane_engine_pkg::PW-1:0]    actAddr
);
    import lane_engine_pkg::*;

    typedef struct packed {
        state_t                   state;
        act_t [1:0][QD-1:0]       q;
        logic                     cur;
        logic [CW-1:0]            ccnt;
        logic [CW-1:0]            ncnt;
        logic [CW-1:0]            rdIdx;
        act_t                     act;
        tword_t                   word;
        logic [PW-1:0]            ptr;
        logic                     noSig;
        logic                     redir;
        logic                     defHop;
        logic [2:0]               lastRefill;
        logic [PW-1:0]            stream_buf_pointer;
        logic                     memRd;
        logic [PW-1:0]            memAddr;
        logic                     actReq;
        logic [PW-1:0]            actAddr;
        logic                     run;
        logic [2:0]               issue;
        logic                     defById;
        logic                     hold;
        logic                     dead;
        logic [31:0]              reg0;
        logic [PW-1:0]            dsb;
        logic                     pready;
        logic [31:0]              prdata;
        logic                     pslverr;
    } st_t;

    st_t s_q;
    st_t s_d;

    // ----------------------------------------------------------------
    // combinational helpers
    // ----------------------------------------------------------------
    act_t          popAct;
    logic          flagProp;
    logic [7:0]    label;
    logic          sigOk;
    logic          pushValid;
    act_t          pushEnt;
    logic [PW-1:0] popPtr;
    logic [PW-1:0] epsAddr;
    logic          apbXfer;
    logic          failDead;
    logic          holdSet;

    assign popAct   = s_q.q[s_q.cur][s_q.rdIdx[CW-2:0]];
    assign flagProp = (s_q.act.ptype == TT_FLAG) || (s_q.act.ptype == TT_FLAGMAJ)
                   || (s_q.act.ptype == TT_FLAGDEF);
    assign label    = flagProp ? s_q.reg0[7:0] : streamWord;
    assign sigOk    = s_q.noSig || (label == s_q.word.sig);
    assign epsAddr  = s_q.dsb + {8'h00, s_q.word.att};
    assign apbXfer  = psel && penable && s_q.pready;

    always_comb
    begin
        popPtr = {4'h0, popAct.tgt} + {8'h00, streamWord};
        if (popAct.ptype == TT_COMMON)
            popPtr = {4'h0, popAct.tgt};
        else if ((popAct.ptype == TT_FLAG) || (popAct.ptype == TT_FLAGMAJ)
              || (popAct.ptype == TT_FLAGDEF))
            popPtr = {4'h0, popAct.tgt} + s_q.reg0[PW-1:0];
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [2:0] rbase;
        logic [2:0] rscal;
        rbase     = 3'h0;
        rscal     = 3'h0;
        s_d       = s_q;
        pushValid = 1'b0;
        pushEnt   = '0;
        failDead  = 1'b0;
        holdSet   = 1'b0;
        s_d.memRd  = 1'b0;
        s_d.actReq = 1'b0;

        case (s_q.state)
            S_IDLE:
            begin
                if (s_q.run && (s_q.ccnt != '0))
                    s_d.state = S_POP;
            end
            S_POP:
            begin
                if (s_q.rdIdx != s_q.ccnt)
                begin
                    s_d.act     = popAct;
                    s_d.rdIdx   = s_q.rdIdx + 1'b1;
                    s_d.ptr     = popPtr;
                    s_d.memAddr = s_q.dsb + popPtr;
                    s_d.memRd   = 1'b1;
                    s_d.noSig   = 1'b0;
                    s_d.redir   = 1'b0;
                    s_d.defHop  = 1'b0;
                    s_d.state   = S_WAIT;
                end
                else
                    s_d.state = S_END;
            end
            S_WAIT:
            begin
                if (memAck)
                begin
                    s_d.word  = tword_t'(memRdata);
                    s_d.state = S_EXEC;
                end
            end
            S_EXEC:
            begin
                s_d.state = S_POP;
                if (s_q.defHop)
                begin
                    // second fetch of a default by address: its target plus the input
                    s_d.ptr     = {4'h0, s_q.word.tgt} + {8'h00, streamWord};
                    s_d.memAddr = s_q.dsb + s_d.ptr;
                    s_d.memRd   = 1'b1;
                    s_d.defHop  = 1'b0;
                    s_d.state   = S_WAIT;
                end
                else if (sigOk)
                begin
                    pushEnt.tgt = s_q.word.tgt;
                    pushValid   = 1'b1;
                    case (s_q.word.typ)
                        TT_EPS:
                        begin
                            pushValid   = 1'b0;
                            s_d.ptr     = {8'h00, s_q.word.att};
                            s_d.memAddr = epsAddr;
                            s_d.memRd   = 1'b1;
                            s_d.noSig   = 1'b1;
                            s_d.state   = S_WAIT;
                        end
                        TT_BASIC:
                            s_d.lastRefill = 3'h0;
                        TT_REFILL:
                            s_d.lastRefill = s_q.word.att[2:0];
                        TT_MAJ, TT_DEF, TT_FLAGMAJ, TT_FLAGDEF:
                        begin
                            pushEnt.ptype  = s_q.word.typ;
                            pushEnt.pval   = s_q.word.att;
                            s_d.lastRefill = 3'h0;
                        end
                        TT_FLAG, TT_COMMON, TT_PERSIST:
                        begin
                            pushEnt.ptype  = s_q.word.typ;
                            s_d.lastRefill = 3'h0;
                        end
                        TT_BASICWA, TT_REFILLWA, TT_FLAGWA, TT_COMMONWA:
                        begin
                            rbase = s_q.word.att[5:3];
                            rscal = s_q.word.att[2:0];
                            s_d.lastRefill = 3'h0;
                            if (s_q.word.typ == TT_FLAGWA)
                                pushEnt.ptype = TT_FLAG;
                            if (s_q.word.typ == TT_COMMONWA)
                                pushEnt.ptype = TT_COMMON;
                            if (s_q.word.typ == TT_REFILLWA)
                            begin
                                rbase = s_q.word.att[4:2];
                                rscal = {1'b0, s_q.word.att[1:0]};
                                s_d.lastRefill = s_q.word.att[7:5];
                            end
                            s_d.actReq  = 1'b1;
                            if ((s_q.word.typ == TT_REFILLWA)
                             || (s_q.word.att[7:6] == MODE_REL))
                                s_d.actAddr = s_q.dsb + s_q.ptr
                                            + rel_addr(rbase, rscal, s_q.word.sig);
                            else
                                s_d.actAddr = epsAddr;
                        end
                        default:
                        begin
                            pushValid = 1'b0;
                            failDead  = 1'b1;
                        end
                    endcase
                    if (pushEnt.ptype == TT_COMMON)
                    begin
                        s_d.hold = 1'b1;
                        holdSet  = 1'b1;
                    end
                end
                else if (s_q.redir)
                    failDead = 1'b1;
                else if ((s_q.act.ptype == TT_MAJ) || (s_q.act.ptype == TT_FLAGMAJ))
                begin
                    s_d.ptr     = {8'h00, s_q.act.pval};
                    s_d.memAddr = s_q.dsb + {8'h00, s_q.act.pval};
                    s_d.memRd   = 1'b1;
                    s_d.noSig   = 1'b1;
                    s_d.redir   = 1'b1;
                    s_d.state   = S_WAIT;
                end
                else if ((s_q.act.ptype == TT_DEF) || (s_q.act.ptype == TT_FLAGDEF))
                begin
                    // identifier form adds the input at once, address form hops first
                    s_d.ptr = {8'h00, s_q.act.pval};
                    if (s_q.defById)
                        s_d.ptr = {8'h00, s_q.act.pval} + {8'h00, streamWord};
                    s_d.defHop  = !s_q.defById;
                    s_d.memAddr = s_q.dsb + s_d.ptr;
                    s_d.memRd   = 1'b1;
                    s_d.redir   = 1'b1;
                    s_d.state   = S_WAIT;
                end
                else
                    failDead = 1'b1;

                if (failDead)
                    s_d.dead = 1'b1;
            end
            S_END:
            begin
                s_d.stream_buf_pointer = s_q.stream_buf_pointer + {13'h0000, s_q.issue}
                        - {13'h0000, s_q.lastRefill};
                s_d.lastRefill = 3'h0;
                s_d.cur   = !s_q.cur;
                s_d.ccnt  = s_q.ncnt;
                s_d.ncnt  = '0;
                s_d.rdIdx = '0;
                s_d.state = (s_q.ncnt == '0) ? S_IDLE : S_POP;
                if (s_q.ncnt == '0)
                    s_d.run = 1'b0;
            end
            default:
                s_d.state = S_IDLE;
        endcase

        // a full next-stage queue drops the push
        if (pushValid && (s_q.ncnt != CW'(QD)))
        begin
            s_d.q[!s_q.cur][s_q.ncnt[CW-2:0]] = pushEnt;
            s_d.ncnt = s_q.ncnt + 1'b1;
        end

        // ------------------------------------------------------------
        // APB slave, one wait state per transfer
        // ------------------------------------------------------------
        s_d.pready = psel && penable && !s_q.pready;
        if (psel && penable && !s_q.pready)
        begin
            s_d.pslverr = 1'b0;
            s_d.prdata  = 32'h0000_0000;
            if (paddr == OFS_CTRL)
            begin
                s_d.prdata[CB_RUN]            = s_q.run;
                s_d.prdata[CB_ISSUE+2:CB_ISSUE] = s_q.issue;
                s_d.prdata[CB_DEFID]          = s_q.defById;
                s_d.prdata[CB_HOLD]           = s_q.hold;
                s_d.prdata[CB_DEAD]           = s_q.dead;
                s_d.prdata[CB_BUSY]           = (s_q.state != S_IDLE);
            end
            else if (paddr == OFS_REG0)
                s_d.prdata = s_q.reg0;
            else if (paddr == OFS_DSB)
                s_d.prdata[PW-1:0] = s_q.dsb;
            else if (paddr == OFS_SBP)
                s_d.prdata[PW-1:0] = s_q.stream_buf_pointer;
            else if (paddr == OFS_PUSH)
                s_d.prdata[2*CW-1:0] = {s_q.ncnt, s_q.ccnt};
            else
                s_d.pslverr = 1'b1;
        end
        if (apbXfer && pwrite)
        begin
            if (paddr == OFS_CTRL)
            begin
                s_d.run     = pwdata[CB_RUN];
                s_d.issue   = pwdata[CB_ISSUE+2:CB_ISSUE];
                s_d.defById = pwdata[CB_DEFID];
                // write one clears, but a flag set in this cycle survives
                if (pwdata[CB_HOLD] && !holdSet)
                    s_d.hold = 1'b0;
                if (pwdata[CB_DEAD] && !failDead)
                    s_d.dead = 1'b0;
            end
            else if (paddr == OFS_REG0)
                s_d.reg0 = pwdata;
            else if (paddr == OFS_DSB)
                s_d.dsb = pwdata[PW-1:0];
            else if ((paddr == OFS_SBP) && (s_q.state == S_IDLE))
                s_d.stream_buf_pointer = pwdata[PW-1:0];
            else if ((paddr == OFS_PUSH) && (s_q.state == S_IDLE)
                  && (s_q.ccnt != CW'(QD)))
            begin
                s_d.q[s_q.cur][s_q.ccnt[CW-2:0]] = act_t'(pwdata[$bits(act_t)-1:0]);
                s_d.ccnt = s_q.ccnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q       <= '0;
            s_q.state <= S_IDLE;
            s_q.issue <= ISSUE_RST;
        end
        else
            s_q <= s_d;
    end

    assign pready    = s_q.pready;
    assign prdata    = s_q.prdata;
    assign pslverr   = s_q.pslverr;
    assign memRd     = s_q.memRd;
    assign memAddr   = s_q.memAddr;
    assign streamPtr = s_q.stream_buf_pointer;
    assign actReq    = s_q.actReq;
    assign actAddr   = s_q.actAddr;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    logic isExec;
    assign isExec = (s_q.state == S_EXEC) && !s_q.defHop;

    property p_pop_fetch;
        (s_q.state == S_POP) && (s_q.rdIdx != s_q.ccnt) |=> memRd ##1 !memRd;
    endproperty
    a_pop_fetch: assert property (p_pop_fetch) else $error("pop gave no fetch");

    property p_stage_sbp;
        (s_q.state == S_END) |=> streamPtr == $past(s_q.stream_buf_pointer)
            + {13'h0000, $past(s_q.issue)} - {13'h0000, $past(s_q.lastRefill)};
    endproperty
    a_stage_sbp: assert property (p_stage_sbp) else $error("bad pointer advance");

    property p_common_ptr;
        (s_q.state == S_POP) && (s_q.rdIdx != s_q.ccnt) && (popAct.ptype == TT_COMMON)
            |=> memAddr == s_q.dsb + {4'h0, s_q.act.tgt};
    endproperty
    a_common_ptr: assert property (p_common_ptr) else $error("common ptr wrong");

    property p_basic_ptr;
        (s_q.state == S_POP) && (s_q.rdIdx != s_q.ccnt) && (popAct.ptype == TT_BASIC)
            |=> memAddr == s_q.dsb + {4'h0, s_q.act.tgt} + {8'h00, $past(streamWord)};
    endproperty
    a_basic_ptr: assert property (p_basic_ptr) else $error("basic ptr wrong");

    property p_dead;
        isExec && !sigOk && (s_q.redir || (s_q.act.ptype == TT_BASIC))
            |=> s_q.dead && (s_q.state == S_POP) && !memRd;
    endproperty
    a_dead: assert property (p_dead) else $error("dead not flagged");

    property p_push_basic;
        isExec && sigOk && (s_q.word.typ == TT_BASIC)
            |-> pushValid && (pushEnt.ptype == TT_BASIC) && (pushEnt.pval == 8'h00);
    endproperty
    a_push_basic: assert property (p_push_basic) else $error("basic push wrong");

    property p_eps_fetch;
        isExec && sigOk && (s_q.word.typ == TT_EPS)
            |=> memRd && (memAddr == $past(epsAddr)) && s_q.noSig;
    endproperty
    a_eps_fetch: assert property (p_eps_fetch) else $error("epsilon fetch wrong");

    property p_maj_fail;
        isExec && !sigOk && !s_q.redir && (s_q.act.ptype == TT_MAJ)
            |=> memRd && (memAddr == s_q.dsb + {8'h00, s_q.act.pval}) ##[1:300] (s_q.state == S_EXEC);
    endproperty
    a_maj_fail: assert property (p_maj_fail) else $error("majority fetch wrong");

    property p_hold;
        isExec && sigOk && (s_q.word.typ == TT_COMMON) |=> s_q.hold;
    endproperty
    a_hold: assert property (p_hold) else $error("hold not set");

    c_stage_swap:   cover property ((s_q.state == S_END) && (s_q.ncnt != '0));
    c_default_hop:  cover property (s_q.defHop ##[1:20] isExec && sigOk);
    c_action_fetch: cover property (actReq);
    c_dead:         cover property (isExec && failDead);

endmodule : lane_transition_engine

// ---- dv/lane_mem_model.sv ----
// local memory and stream buffer model facing the lane engine
// assumes the bench preloads mem and words before setting run
`timescale 1ns/10ps
module lane_mem_model
(
    input  wire logic        clock,
    input  wire logic        memRd,
    input  wire logic [15:0] memAddr,
    output logic             memAck,
    output logic [31:0]      memRdata,
    input  wire logic [15:0] streamPtr,
    output logic [7:0]       streamWord
);
    logic [31:0] mem   [256];
    logic [7:0]  words [16];
    initial memAck = 1'b0;
    // one ack a cycle after each request; data is garbled outside the ack
    always @(posedge clock)
        memAck <= memRd;
    assign memRdata   = memAck ? mem[memAddr[7:0]] : ~mem[memAddr[7:0]];
    assign streamWord = words[streamPtr[3:0]];
endmodule : lane_mem_model

// ---- dv/lane_transition_engine_tb.sv ----
// bench for the lane transition engine: apb tasks and two two-stage runs
// assumes lane_mem_model answers every memory read one cycle late
`timescale 1ns/10ps
module lane_transition_engine_tb;
    import lane_engine_pkg::*;
    logic        clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, memRdata, rd;
    logic        pready, pslverr, memRd, memAck, actReq, err;
    logic [15:0] memAddr, streamPtr, actAddr;
    logic [7:0]  streamWord;
    logic [15:0] seen [$];
    int          errors = 0, check_count = 0;
    int          actCount = 0;
    logic [15:0] actSeen = 16'h0000;
    lane_transition_engine uut (.clock, .arst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .memRd, .memAddr, .memAck, .memRdata,
        .streamPtr, .streamWord, .actReq, .actAddr);
    lane_mem_model uMem (.clock, .memRd, .memAddr, .memAck, .memRdata, .streamPtr,
        .streamWord);
    task print_verdict;
        if (errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // request held until pready is sampled high at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        // one idle edge first, so a following call never re-drives psel in the release step
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge clock) penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // start the engine and poll until run drops
    task run_stage(input logic [31:0] c);
        apb(1, OFS_CTRL, c);
        repeat (60)
        begin
            apb(0, OFS_CTRL, 0);
            if (rd[0] === 1'b0)
                break;
        end
    endtask : run_stage
    always @(posedge clock)
        if (memRd === 1'b1)
            seen.push_back(memAddr);
    always @(posedge clock)
        if (actReq === 1'b1)
        begin
            actCount <= actCount + 1;
            actSeen  <= actAddr;
        end
    initial
    begin
        forever #20 clock = ~clock;
    end
    initial
    begin
        #200000 errors++;
        print_verdict();
    end
    initial
    begin
        uMem.words = '{0: 8'h03, 1: 8'h05, 2: 8'h04, default: 8'h00};
        uMem.mem[8'h13] = {8'h03, 12'h020, TT_BASIC, 8'h00};
        uMem.mem[8'h25] = {8'h77, 12'h030, TT_BASIC, 8'h00};
        uMem.mem[8'h40] = {8'h04, 12'h000, TT_EPS, 8'h60};
        uMem.mem[8'h60] = {8'h00, 12'h084, TT_COMMON, 8'h00};
        uMem.mem[8'h84] = {8'h55, 12'h000, TT_BASIC, 8'h00};
        uMem.mem[8'h90] = {8'h00, 12'h084, TT_BASICWA, 8'h12};
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        apb(0, OFS_CTRL, 0);
        chk("ctrl reset", rd, 32'h0000_0002);
        apb(0, 12'hFFC, 0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        apb(1, OFS_DSB, 0);
        apb(1, OFS_SBP, 0);
        // push word: target in bits 23:12, property type 11:8, value 7:0
        apb(1, OFS_PUSH, 32'h0001_0000);
        run_stage(32'h0000_0003);
        chk("ctrl end", rd, 32'h0000_0202);
        apb(0, OFS_SBP, 0);
        chk("pointer", rd, 32'h0000_0002);
        apb(0, OFS_PUSH, 0);
        chk("counts", rd, 32'h0);
        // second run: common, epsilon, majority and action paths with a moved data base
        apb(1, OFS_DSB, 32'h0000_0100);
        apb(1, OFS_PUSH, 32'h0004_0600);
        apb(1, OFS_PUSH, 32'h0008_0390);
        apb(0, OFS_PUSH, 0);
        chk("queued", rd, 32'h0000_0002);
        run_stage(32'h0000_0203);
        chk("ctrl two", rd, 32'h0000_0302);
        apb(0, OFS_SBP, 0);
        chk("pointer two", rd, 32'h0000_0004);
        apb(0, OFS_PUSH, 0);
        chk("counts two", rd, 32'h0);
        chk("reads", seen.size(), 8);
        chk("ptr one", {16'h0, seen[0]}, 32'h13);
        chk("ptr two", {16'h0, seen[1]}, 32'h25);
        chk("common ptr", {16'h0, seen[2]}, 32'h140);
        chk("eps fetch", {16'h0, seen[3]}, 32'h160);
        chk("input ptr", {16'h0, seen[4]}, 32'h184);
        chk("maj fetch", {16'h0, seen[5]}, 32'h190);
        chk("common carry", {16'h0, seen[6]}, 32'h184);
        chk("action push", {16'h0, seen[7]}, 32'h184);
        chk("action count", actCount, 1);
        chk("action addr", {16'h0, actSeen}, 32'h112);
        print_verdict();
    end
endmodule : lane_transition_engine_tb
